// ### core/pif_pkg.sv
// Contract
// - Flags set regardless of enable bits
// - This is first of two flag registers
// - Bit 7 unimplemented, reads zero
// - Bit 6 conversion done, sticky
// - Bit 5 mirrors receive buffer full
// - Bit 4 mirrors transmit buffer empty
// - Bit 3 serial transfer done, sticky
// - Bit 2 sets on capture event in capture mode
// - Bit 2 sets on compare in compare mode; unused PWM
// - Bit 1 timer-2 period match, sticky
// - Bit 0 timer-1 overflow, sticky
package pif_pkg;
  localparam int unsigned ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFF_FLAGS  = 4'h0;
  localparam logic [3:0] OFF_MASK   = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_MODE   = 4'h3;
  // Field positions of the flag register
  localparam int unsigned BIT_OVF  = 0;
  localparam int unsigned BIT_PER  = 1;
  localparam int unsigned BIT_CCP  = 2;
  localparam int unsigned BIT_SSP  = 3;
  localparam int unsigned BIT_TXE  = 4;
  localparam int unsigned BIT_RXF  = 5;
  localparam int unsigned BIT_ADC  = 6;
  localparam int unsigned BIT_UNIM = 7;
  // Bits software may write (read-write flags)
  localparam logic [7:0] RW_MASK    = 8'h4F;
  // Bits that are live status from peripherals
  localparam logic [7:0] LIVE_MASK  = 8'h30;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [1:0] MODE_RST   = 2'h0;
  // Capture/compare unit modes
  typedef enum logic [1:0] {
    PIF_CAPTURE = 2'h0,
    PIF_COMPARE = 2'h1,
    PIF_PWM     = 2'h2,
    PIF_OFF     = 2'h3
  } pif_ccp_mode_t;
endpackage

// ### core/pif_evt_if.sv
`timescale 1ns/100ps
`default_nettype none
// Per-bit set requests and clear requests for the sticky flag bank
interface pif_evt_if;
  logic [7:0] set_req;
  logic [7:0] clr_req;
  logic [7:0] flags;
  modport ctl (output set_req, output clr_req, input flags);
  modport bank (input set_req, input clr_req, output flags);
endinterface
`default_nettype wire

// ### core/pif_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none
module pif_flag_bank (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Set and clear traffic
  pif_evt_if.bank   evt
);
  typedef struct packed {
    logic [7:0] flags;
  } pif_bank_t;
  pif_bank_t st;
  pif_bank_t next_st;

  // Set wins over clear so no event is lost in the clearing cycle
  always_comb begin
    next_st = st;
    for (int i = 0; i < 8; i++) begin
      if (evt.set_req[i]) begin
        next_st.flags[i] = 1'b1;
      end else if (evt.clr_req[i]) begin
        next_st.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st.flags <= pif_pkg::FLAGS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign evt.flags = st.flags;

  a_set_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.set_req[0] && evt.clr_req[0]) |=> evt.flags[0])
    else $error("set lost against clear");
endmodule // pif_flag_bank
`default_nettype wire

// ### core/pif_flags_one.sv
`timescale 1ns/100ps
`default_nettype none
// First peripheral interrupt flag register with mask and one irq line
module pif_flags_one (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // Register port
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Peripheral events, one-cycle pulses
  input  wire logic       conv_done_in,
  input  wire logic       sync_done_in,
  input  wire logic       capture_in,
  input  wire logic       compare_in,
  input  wire logic       period_match_in,
  input  wire logic       overflow_in,
  // Serial buffer levels
  input  wire logic       rx_full_in,
  input  wire logic       tx_empty_in,
  // Interrupt
  output logic            irq_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] mask;
    logic [1:0] mode;
    logic       irq;
  } pif_top_t;
  pif_top_t st;
  pif_top_t next_st;
  logic [7:0] flags_all;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       ccp_hit;

  pif_evt_if evt ();

  pif_flag_bank u_bank (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .evt        (evt)
  );

  // Capture or compare event depending on mode; PWM ignores both
  always_comb begin
    unique case (pif_pkg::pif_ccp_mode_t'(st.mode))
      pif_pkg::PIF_CAPTURE: ccp_hit = capture_in;
      pif_pkg::PIF_COMPARE: ccp_hit = compare_in;
      pif_pkg::PIF_PWM:     ccp_hit = 1'b0;
      pif_pkg::PIF_OFF:     ccp_hit = 1'b0;
    endcase
  end

  // Set requests ignore every enable, so masking only gates irq and the status read
  always_comb begin
    set_v = 8'h00;
    set_v[pif_pkg::BIT_ADC] = conv_done_in;
    set_v[pif_pkg::BIT_SSP] = sync_done_in;
    set_v[pif_pkg::BIT_CCP] = ccp_hit;
    set_v[pif_pkg::BIT_PER] = period_match_in;
    set_v[pif_pkg::BIT_OVF] = overflow_in;
  end

  // Writing one clears a read-write flag; other bits ignore writes
  always_comb begin
    clr_v = 8'h00;
    if (wr_in && (addr_in == pif_pkg::OFF_FLAGS)) begin
      clr_v = wdata_in & pif_pkg::RW_MASK;
    end
  end

  assign evt.set_req = set_v;
  assign evt.clr_req = clr_v;

  // Live buffer bits follow the serial unit; bit 7 forced low
  always_comb begin
    flags_all = evt.flags & pif_pkg::RW_MASK;
    flags_all[pif_pkg::BIT_RXF] = rx_full_in;
    flags_all[pif_pkg::BIT_TXE] = tx_empty_in;
  end

  // Register writes, read mux and the interrupt level
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (wr_in && (addr_in == pif_pkg::OFF_MASK)) begin
      next_st.mask = wdata_in & ~8'h80;
    end
    if (wr_in && (addr_in == pif_pkg::OFF_MODE)) begin
      next_st.mode = wdata_in[1:0];
    end
    if (rd_in) begin
      unique case (addr_in)
        pif_pkg::OFF_FLAGS:  next_st.rdata = flags_all;
        pif_pkg::OFF_MASK:   next_st.rdata = st.mask;
        pif_pkg::OFF_STATUS: next_st.rdata = flags_all & st.mask;
        pif_pkg::OFF_MODE:   next_st.rdata = {6'h00, st.mode};
        default:             next_st.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
    next_st.irq = |(flags_all & st.mask);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st.rdata      <= 8'h00;
      st.mask       <= pif_pkg::MASK_RST;
      st.mode       <= pif_pkg::MODE_RST;
      st.irq        <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign irq_out   = st.irq;

  // Checks on the block's own behaviour
  // Clear requests are read from clr_v, a plain net, so the checks see
  // sampled values; a sequence cannot be negated inside an expression
  sequence s_period_kept;
    period_match_in ##1 !clr_v[pif_pkg::BIT_PER];
  endsequence
  sequence s_conv_kept;
    conv_done_in ##1 !clr_v[pif_pkg::BIT_ADC];
  endsequence
  sequence s_compare_hit;
    (st.mode == 2'h1) && compare_in;
  endsequence
  sequence s_ovf_clear;
    clr_v[pif_pkg::BIT_OVF] && !overflow_in;
  endsequence

  a_top_bit_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rd_in |=> rdata_out[7] == 1'b0)
    else $error("bit 7 read nonzero");
  a_adc_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    conv_done_in |=> evt.flags[pif_pkg::BIT_ADC])
    else $error("conversion flag not set");
  a_rx_live: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (rd_in && addr_in == pif_pkg::OFF_FLAGS) |=> rdata_out[5] == $past(rx_full_in))
    else $error("rx bit not live");
  a_tx_live: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (rd_in && addr_in == pif_pkg::OFF_FLAGS) |=> rdata_out[4] == $past(tx_empty_in))
    else $error("tx bit not live");
  a_ssp_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags[3] && !clr_v[3]) |=> evt.flags[3])
    else $error("sync flag dropped");
  a_pwm_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st.mode == 2'h2 && !evt.flags[2]) |=> !evt.flags[2])
    else $error("ccp flag set in pwm");
  a_capture_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st.mode == 2'h0 && capture_in) |=> evt.flags[2])
    else $error("capture not flagged");
  a_period_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_period_kept |=> evt.flags[1])
    else $error("period flag lost");
  a_ovf_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_ovf_clear |=> !evt.flags[0])
    else $error("overflow not cleared");

  // Stickiness of the remaining write-one-clear flags
  a_conv_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags[6] && !clr_v[6]) |=> evt.flags[6])
    else $error("conversion flag dropped");
  a_conv_kept: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_conv_kept |=> evt.flags[6])
    else $error("conversion flag lost");
  a_ccp_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags[2] && !clr_v[2]) |=> evt.flags[2])
    else $error("ccp flag dropped");
  a_per_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags[1] && !clr_v[1]) |=> evt.flags[1])
    else $error("period flag dropped");
  a_ovf_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags[0] && !clr_v[0]) |=> evt.flags[0])
    else $error("overflow flag dropped");

  // Compare mode takes the match pulse instead of the capture pulse
  a_compare_sets: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_compare_hit |=> evt.flags[2])
    else $error("compare not flagged");

  // Clearing works on the sticky bits when no event collides
  a_conv_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clr_v[6] && !conv_done_in) |=> !evt.flags[6])
    else $error("conversion not cleared");
  a_sync_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (clr_v[3] && !sync_done_in) |=> !evt.flags[3])
    else $error("sync flag not cleared");

  // Any event lands in the bank whatever the mask holds
  a_ignore_enable: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (set_v != 8'h00) |=> ((evt.flags & $past(set_v)) == $past(set_v)))
    else $error("event lost under mask");

  // Bank bits behind the live and unused positions never set
  a_ro_bank_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (evt.flags & 8'hB0) == 8'h00)
    else $error("read-only bank bit set");
  a_mask_top_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !st.mask[7])
    else $error("mask bit 7 set");

  // Read data stand one cycle only, zero otherwise
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data without read");
  a_irq_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ##1 irq_out == |($past(flags_all) & $past(st.mask)))
    else $error("irq level wrong");
  a_reset_clear: assert property (@(posedge clk_in)
    sys_rst_in |=> (evt.flags == 8'h00 && !irq_out))
    else $error("reset did not clear");
endmodule // pif_flags_one
`default_nettype wire

// ### dv/pif_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
// Peripheral side: bench requests become event pulses and buffer levels
module pif_periph_model (
  // Clock
  input  wire logic       clk_in,
  // Bench requests: levels on [7:6], event pulses on [5:0]
  input  wire logic [7:0] fire_in,
  // Pins toward the flag block
  output var  logic [7:0] pin_out
);
  // Launched after the edge so the block samples a settled pulse
  always @(posedge clk_in) pin_out <= fire_in;
endmodule // pif_periph_model
`default_nettype wire

// ### dv/peripheral_irq_flag_reg1_tb.sv
`timescale 1ns/100ps
`default_nettype none
module peripheral_irq_flag_reg1_tb;
  logic       clk_in = 1'h0;
  logic       sys_rst_in = 1'h1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'h0;
  logic       rd_in = 1'h0;
  logic       rd_pend = 1'h0;
  logic [5:0] ev = 6'h00;
  logic [1:0] lv = 2'h0;
  logic [7:0] pins;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  int         mismatches = 0;
  int         checks_done = 0;
  int         seed = 32'h4f13;
  int         r;
  // 50 MHz clock
  initial forever #10 clk_in = ~clk_in;
  pif_periph_model i_pif_periph_model (.clk_in(clk_in), .fire_in({lv, ev}), .pin_out(pins));
  pif_flags_one i_pif_flags_one (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .conv_done_in(pins[4]), .sync_done_in(pins[3]), .capture_in(pins[2]),
    .compare_in(pins[5]), .period_match_in(pins[1]), .overflow_in(pins[0]),
    .rx_full_in(pins[6]), .tx_empty_in(pins[7]), .irq_out(irq_out));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // One bus cycle; for a read, d is the value the next cycle must show
  task automatic bus(input logic w, input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= rd;
    addr_in <= a;
    wdata_in <= d;
    if (rd) exp_q.push_back(d);
  endtask
  // Event pulse one cycle long; the bus idles meanwhile
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    ev <= v;
    @(posedge clk_in);
    ev <= 6'h00;
  endtask
  // Expected flags; capture counts only in mode 0, compare only in mode 1
  function automatic logic [7:0] exp_of(input logic [5:0] v, input int m);
    exp_of = {1'h0, v[4], 2'h0, v[3], (v[2] && m == 0) || (v[5] && m == 1), v[1], v[0]};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe, so compare mid-cycle
  always @(posedge clk_in) rd_pend <= rd_in;
  always @(negedge clk_in) if (rd_pend) begin
    e = exp_q.pop_front();
    check(rdata_out, e);
  end
  // Bounded run: under two hundred cycles expected
  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    for (int a = 0; a < 4; a++) bus(0, 1, a[3:0], 8'h00);
    bus(1, 0, 4'hF, 8'hFF);
    bus(0, 1, 4'hF, 8'h00);
    bus(1, 0, pif_pkg::OFF_MASK, 8'hFF);
    bus(0, 1, pif_pkg::OFF_MASK, 8'h7F);
    bus(1, 0, pif_pkg::OFF_MASK, 8'h00);
    bus(1, 0, pif_pkg::OFF_FLAGS, 8'hFF);
    bus(0, 1, pif_pkg::OFF_FLAGS, 8'h00);
    $display("test reset_access done");
    // Every source alone in modes 0 to 2, enables off, then write-one-clear
    for (int m = 0; m < 3; m++) begin
      bus(1, 0, pif_pkg::OFF_MODE, m[7:0]);
      for (int b = 0; b < 6; b++) begin
        pulse(6'h01 << b);
        bus(0, 1, pif_pkg::OFF_FLAGS, exp_of(6'h01 << b, m));
        bus(1, 0, pif_pkg::OFF_FLAGS, 8'hFF);
        bus(0, 1, pif_pkg::OFF_FLAGS, 8'h00);
      end
    end
    $display("test single_events done");
    // Random event mixes in compare mode
    bus(1, 0, pif_pkg::OFF_MODE, 8'h01);
    repeat (8) begin
      r = $random(seed);
      pulse(r[5:0]);
      bus(0, 1, pif_pkg::OFF_FLAGS, exp_of(r[5:0], 1));
      bus(1, 0, pif_pkg::OFF_FLAGS, 8'hFF);
    end
    $display("test random_mix done");
    // Buffer levels show live and ignore writes
    lv <= 2'h3;
    bus(1, 0, pif_pkg::OFF_FLAGS, 8'hFF);
    bus(0, 1, pif_pkg::OFF_FLAGS, 8'h30);
    lv <= 2'h0;
    repeat (2) bus(0, 0, 4'h0, 8'h00);
    bus(0, 1, pif_pkg::OFF_FLAGS, 8'h00);
    bus(0, 0, 4'h0, 8'h00);
    @(negedge clk_in) check(rdata_out, 8'h00);
    $display("test buffer_levels done");
    // Masked-out source stays quiet; masked-in one raises the line
    bus(1, 0, pif_pkg::OFF_MASK, 8'h01);
    pulse(6'h02);
    bus(0, 1, pif_pkg::OFF_STATUS, 8'h00);
    @(negedge clk_in) check({7'h00, irq_out}, 8'h00);
    pulse(6'h01);
    bus(0, 1, pif_pkg::OFF_STATUS, 8'h01);
    bus(0, 0, 4'h0, 8'h00);
    @(negedge clk_in) check({7'h00, irq_out}, 8'h01);
    bus(1, 0, pif_pkg::OFF_FLAGS, 8'hFF);
    repeat (2) bus(0, 0, 4'h0, 8'h00);
    @(negedge clk_in) check({7'h00, irq_out}, 8'h00);
    $display("test interrupt done");
    finish_test();
  end
endmodule // peripheral_irq_flag_reg1_tb
`default_nettype wire
